// ==== design/cbs_defines.svh ====
// cbs_defines.svh: constants of the cpu bus request scheduler
// assumes it is included by cbs_pkg, the scheduler top and the test bench only
// Overview of operation
// [R1] a data operation beats a prefetch that is ready in the same slot
// [R2] a started prefetch cycle always completes before data goes out
// [R3] a write on a busy bus is posted and the execution side released
// [R4] one posted write only; a second write stalls until it drains
// [R5] data cycles follow any other cycle without idle clocks; here not after a coprocessor or byte cycle, which must end first
// [R6] coprocessor transfers start on its request, then run on our cycles
// [R7] coprocessor transfer beats data and prefetch when all ask at once
// [R8] each coprocessor operand transfer takes at least two bus cycles
// [R9] coprocessor cycles use the same handshake as ordinary cycles
// [R10] no data or prefetch cycle inside a coprocessor word transfer
// [R11] coprocessor side cycles are always full 16-bit words
// [R12] odd memory address splits into two byte cycles, three in total
// [R13] priority: lock, second half, hold, coprocessor, data, prefetch
// [R14] prefetch is requested when two or more queue bytes are empty
// [R15] an early data notice suppresses new prefetch requests
// [R16] reset empties the write slot, drops sequences, grants nothing
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH
`define CBS_ADDR_W 24
`define CBS_WORD_W 16
`define CBS_PF_DEPTH 8
`define CBS_PF_CNT_W 4
`define CBS_PF_MIN_EMPTY 3'h2
`define CBS_COP_PORT 24'h000100
`define CBS_BE_WORD 2'h3
`define CBS_BE_LO 2'h1
`define CBS_BE_HI 2'h2
`define CBS_ADDR_ONE 24'h000001
`define CBS_CP_CNT_SPLIT 2'h3
`define CBS_CP_CNT_WORD 2'h2
`endif

// ==== design/cbs_pkg.sv ====
// cbs_pkg: types shared by the scheduler and its bench
// assumes cbs_defines.svh is on the include path
package cbs_pkg;
`include "cbs_defines.svh"
   typedef logic [`CBS_ADDR_W-1:0] cbs_addr_t;
   typedef logic [`CBS_WORD_W-1:0] cbs_word_t;
   // one bus cycle as handed to the cycle generator
   typedef struct packed {
      cbs_addr_t addr;
      cbs_word_t wdata;
      logic write;
      logic io;
      logic coproc;
      logic [1:0] be;
      logic lock;
   } cbs_cycle_t;
   // execution side request
   typedef struct packed {
      cbs_addr_t addr;
      cbs_word_t data;
      logic write;
      logic io;
      logic lock;
   } cbs_xreq_t;
   typedef enum logic [1:0] {TG_PF, TG_EX, TG_CP} cbs_tag_t;
   typedef enum logic [1:0] {PT_WORD, PT_LO, PT_HI} cbs_part_t;
   // bookkeeping carried with a staged or running cycle
   typedef struct packed {
      cbs_tag_t tag;
      cbs_part_t part;
      logic last;
      logic unit;
      logic rd;
   } cbs_info_t;
   typedef enum logic [2:0] {
      SQ_IDLE, SQ_EX_HI, SQ_CP_RD_HI, SQ_CP_DEV_WR, SQ_CP_WR_LO, SQ_CP_WR_HI
   } cbs_seq_t;
endpackage

// ==== design/cbs_fifo.sv ====
// cbs_fifo: flip-flop fifo with valid and ready on both sides
// assumes one clock and an active low asynchronous reset
module cbs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] count_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] cnt_r;
   logic push;
   logic pop;

   // a full fifo refuses, an empty one offers nothing
   assign in_ready_o = cnt_r < CW'(DEPTH);
   assign out_valid_o = cnt_r != '0;
   assign out_data_o = mem_r[rd_ptr_r];
   assign count_o = cnt_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage needs no reset, the count guards it
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule

// ==== design/cbs_scheduler.sv ====
// cbs_scheduler: picks the next local bus cycle among coprocessor,
// execution side and prefetch requests; holds one posted write
// assumes a cycle generator that accepts one cycle at a time and
// pulses bus_done_i once at the end of every accepted cycle
`include "cbs_defines.svh"
module cbs_scheduler
   import cbs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic exec_req_i,
   input wire cbs_xreq_t exec_cmd_i,
   input wire logic exec_soon_i,
   output logic exec_ack_o,
   output cbs_word_t exec_rdata_o,
   input wire logic [2:0] pf_empty_i,
   input wire cbs_addr_t pf_addr_i,
   output logic pf_ack_o,
   output logic pf_valid_o,
   input wire logic pf_ready_i,
   output cbs_word_t pf_data_o,
   input wire logic coproc_transfer_request_i,
   input wire logic coproc_to_mem_i,
   input wire cbs_addr_t coproc_addr_i,
   output logic coproc_ack_o,
   input wire logic hold_req_i,
   output logic hold_ack_o,
   output logic bus_req_o,
   output cbs_cycle_t bus_cmd_o,
   input wire logic bus_accept_i,
   input wire logic bus_done_i,
   input wire cbs_word_t bus_rdata_i
);
   logic breq_r;
   cbs_cycle_t bcmd_r;
   cbs_info_t s_info_r;
   cbs_info_t i_info_r;
   logic infl_r;
   logic ds_vld_r;
   logic ds_iss_r;
   cbs_xreq_t ds_r;
   logic cp_busy_r;
   cbs_addr_t cp_addr_r;
   cbs_word_t cp_data_r;
   cbs_seq_t seq_r;
   cbs_seq_t seq_nxt;
   logic wait_r;
   logic ex_ack_r;
   cbs_word_t ex_rdata_r;
   logic cp_ack_r;
   logic hold_ack_r;
   logic pf_ack_r;
   logic [1:0] pfo_r;
   logic [1:0] cp_cnt_r;
   logic [`CBS_PF_CNT_W-1:0] pf_cnt;
   logic fifo_in_rdy;
   logic stage_free;
   logic unit_busy;
   logic lock_can;
   logic ex_can;
   logic step_can;
   logic cop_can;
   logic pf_can;
   logic pf_room;
   logic ex_take;
   logic done_w;
   logic go_w;
   logic take_ds;
   logic take_cop;
   logic take_pf;
   cbs_cycle_t st_cmd;
   cbs_info_t st_info;
   cbs_cycle_t ex_cmd;
   cbs_info_t ex_info;
   cbs_seq_t ex_seq;
   cbs_cycle_t cp_cmd;
   cbs_info_t cp_info;
   cbs_seq_t cp_seq;
   cbs_cycle_t sp_cmd;
   cbs_info_t sp_info;
   cbs_seq_t sp_seq;
   cbs_word_t asm_base;
   cbs_word_t asm_w;

   function automatic cbs_cycle_t mk_cyc(
      input cbs_addr_t a,
      input cbs_word_t d,
      input logic w,
      input logic io,
      input logic cop,
      input logic [1:0] be,
      input logic lk
   );
      cbs_cycle_t c;
      c.addr = a;
      c.wdata = d;
      c.write = w;
      c.io = io;
      c.coproc = cop;
      c.be = be;
      c.lock = lk;
      return c;
   endfunction

   // candidate terms; a running unit shuts out every newcomer
   assign done_w = bus_done_i && infl_r;
   assign stage_free = (!breq_r || bus_accept_i) && !hold_ack_r; // R5
   assign unit_busy = (seq_r != SQ_IDLE) || wait_r;
   assign ex_can = ds_vld_r && !ds_iss_r && !unit_busy; // R10
   assign lock_can = ex_can && ds_r.lock;
   assign step_can = !wait_r && (seq_r != SQ_IDLE);
   assign cop_can = coproc_transfer_request_i && !cp_busy_r && !cp_ack_r
      && !unit_busy; // R6
   assign pf_room = ({1'b0, pf_cnt} + {3'b000, pfo_r})
      < 5'(`CBS_PF_DEPTH);
   assign pf_can = (pf_empty_i >= `CBS_PF_MIN_EMPTY) // R14
      && !exec_soon_i // R15
      && fifo_in_rdy && pf_room && !unit_busy;
   assign ex_take = exec_req_i && !ds_vld_r && !ex_ack_r;

   // first cycle of an execution side transfer
   always_comb begin
      ex_seq = SQ_IDLE;
      if (ds_r.addr[0]) begin
         // odd word: low byte rides on the high lane first
         ex_cmd = mk_cyc(ds_r.addr, {ds_r.data[7:0], 8'h00}, ds_r.write,
            ds_r.io, 1'b0, `CBS_BE_HI, ds_r.lock);
         ex_info = '{TG_EX, PT_LO, 1'b0, 1'b1, !ds_r.write};
         ex_seq = SQ_EX_HI;
      end else begin
         ex_cmd = mk_cyc(ds_r.addr, ds_r.data, ds_r.write, ds_r.io, 1'b0,
            `CBS_BE_WORD, ds_r.lock);
         ex_info = '{TG_EX, PT_WORD, 1'b1, 1'b0, !ds_r.write};
      end
   end

   // first cycle of a coprocessor word transfer
   always_comb begin
      if (coproc_to_mem_i) begin
         cp_cmd = mk_cyc(`CBS_COP_PORT, 16'h0000, 1'b0, 1'b1, 1'b1,
            `CBS_BE_WORD, 1'b0); // R11
         cp_info = '{TG_CP, PT_WORD, 1'b0, 1'b1, 1'b1};
         cp_seq = SQ_CP_WR_LO;
      end else if (coproc_addr_i[0]) begin
         cp_cmd = mk_cyc(coproc_addr_i, 16'h0000, 1'b0, 1'b0, 1'b1,
            `CBS_BE_HI, 1'b0); // R12
         cp_info = '{TG_CP, PT_LO, 1'b0, 1'b1, 1'b1};
         cp_seq = SQ_CP_RD_HI;
      end else begin
         cp_cmd = mk_cyc(coproc_addr_i, 16'h0000, 1'b0, 1'b0, 1'b1,
            `CBS_BE_WORD, 1'b0);
         cp_info = '{TG_CP, PT_WORD, 1'b0, 1'b1, 1'b1};
         cp_seq = SQ_CP_DEV_WR;
      end
   end

   // following step of a running unit, each after the last one ended
   always_comb begin
      sp_cmd = mk_cyc(`CBS_COP_PORT, cp_data_r, 1'b1, 1'b1, 1'b1,
         `CBS_BE_WORD, 1'b0); // R8
      sp_info = '{TG_CP, PT_WORD, 1'b1, 1'b1, 1'b0};
      sp_seq = SQ_IDLE;
      case (seq_r)
         SQ_EX_HI: begin
            sp_cmd = mk_cyc(ds_r.addr + `CBS_ADDR_ONE,
               {8'h00, ds_r.data[15:8]}, ds_r.write, ds_r.io, 1'b0,
               `CBS_BE_LO, ds_r.lock);
            sp_info = '{TG_EX, PT_HI, 1'b1, 1'b1, !ds_r.write};
         end
         SQ_CP_RD_HI: begin
            sp_cmd = mk_cyc(cp_addr_r + `CBS_ADDR_ONE, 16'h0000, 1'b0,
               1'b0, 1'b1, `CBS_BE_LO, 1'b0); // R12
            sp_info = '{TG_CP, PT_HI, 1'b0, 1'b1, 1'b1};
            sp_seq = SQ_CP_DEV_WR;
         end
         SQ_CP_WR_LO: begin
            if (cp_addr_r[0]) begin
               sp_cmd = mk_cyc(cp_addr_r, {cp_data_r[7:0], 8'h00}, 1'b1,
                  1'b0, 1'b1, `CBS_BE_HI, 1'b0); // R12
               sp_info = '{TG_CP, PT_LO, 1'b0, 1'b1, 1'b0};
               sp_seq = SQ_CP_WR_HI;
            end else begin
               sp_cmd = mk_cyc(cp_addr_r, cp_data_r, 1'b1, 1'b0, 1'b1,
                  `CBS_BE_WORD, 1'b0);
            end
         end
         SQ_CP_WR_HI: begin
            sp_cmd = mk_cyc(cp_addr_r + `CBS_ADDR_ONE,
               {8'h00, cp_data_r[15:8]}, 1'b1, 1'b0, 1'b1, `CBS_BE_LO,
               1'b0);
            sp_info = '{TG_CP, PT_HI, 1'b1, 1'b1, 1'b0};
         end
         default: begin
         end
      endcase
   end

   // priority chain; a pending hold stops lower grants so the bus drains
   always_comb begin
      go_w = 1'b0;
      take_ds = 1'b0;
      take_cop = 1'b0;
      take_pf = 1'b0;
      st_cmd = bcmd_r;
      st_info = s_info_r;
      seq_nxt = seq_r;
      if (!stage_free) begin
         go_w = 1'b0;
      end else if (lock_can) begin // R13
         go_w = 1'b1;
         take_ds = 1'b1;
         st_cmd = ex_cmd;
         st_info = ex_info;
         seq_nxt = ex_seq;
      end else if (step_can) begin // R13
         go_w = 1'b1;
         st_cmd = sp_cmd;
         st_info = sp_info;
         seq_nxt = sp_seq;
      end else if (hold_req_i) begin // R13
         go_w = 1'b0;
      end else if (cop_can) begin // R7
         go_w = 1'b1;
         take_cop = 1'b1;
         st_cmd = cp_cmd;
         st_info = cp_info;
         seq_nxt = cp_seq;
      end else if (ex_can) begin // R1
         go_w = 1'b1;
         take_ds = 1'b1;
         st_cmd = ex_cmd;
         st_info = ex_info;
         seq_nxt = ex_seq;
      end else if (pf_can) begin
         go_w = 1'b1;
         take_pf = 1'b1;
         st_cmd = mk_cyc(pf_addr_i, 16'h0000, 1'b0, 1'b0, 1'b0,
            `CBS_BE_WORD, 1'b0);
         st_info = '{TG_PF, PT_WORD, 1'b1, 1'b0, 1'b1};
      end
   end

   // staged cycle held until the generator accepts it
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         breq_r <= 1'b0;
         bcmd_r <= '0;
         s_info_r <= '0;
      end else if (go_w) begin
         breq_r <= 1'b1;
         bcmd_r <= st_cmd;
         s_info_r <= st_info;
      end else if (bus_accept_i) begin // R9
         breq_r <= 1'b0;
      end
   end

   // running cycle; a started prefetch is never withdrawn
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         infl_r <= 1'b0;
         i_info_r <= '0;
      end else if (bus_accept_i && breq_r) begin // R2
         infl_r <= 1'b1;
         i_info_r <= s_info_r;
      end else if (bus_done_i) begin
         infl_r <= 1'b0;
      end
   end

   // unit sequencer; reset abandons whatever unit was running
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seq_r <= SQ_IDLE; // R16
         wait_r <= 1'b0;
      end else begin
         if (go_w) begin
            seq_r <= seq_nxt;
         end
         if (go_w && st_info.unit) begin // R10
            wait_r <= 1'b1;
         end else if (done_w && i_info_r.unit) begin
            wait_r <= 1'b0;
         end
      end
   end

   // one write slot: taken writes are released at once
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ds_vld_r <= 1'b0; // R16
         ds_iss_r <= 1'b0;
         ds_r <= '0;
      end else if (ex_take) begin // R3
         ds_vld_r <= 1'b1;
         ds_iss_r <= 1'b0;
         ds_r <= exec_cmd_i;
      end else begin
         if (take_ds) begin
            ds_iss_r <= 1'b1;
         end
         if (done_w && i_info_r.tag == TG_EX && i_info_r.last) begin // R4
            ds_vld_r <= 1'b0;
            ds_iss_r <= 1'b0;
         end
      end
   end

   // read data merge; byte halves fill their own half of the word
   assign asm_base = (i_info_r.tag == TG_CP) ? cp_data_r : ex_rdata_r;
   always_comb begin
      case (i_info_r.part)
         PT_LO: asm_w = {asm_base[15:8], bus_rdata_i[15:8]};
         PT_HI: asm_w = {bus_rdata_i[7:0], asm_base[7:0]};
         default: asm_w = bus_rdata_i;
      endcase
   end

   // execution side answers: write on capture, read on last data
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ex_ack_r <= 1'b0;
         ex_rdata_r <= '0;
      end else begin
         ex_ack_r <= (ex_take && exec_cmd_i.write)
            || (done_w && i_info_r.tag == TG_EX && i_info_r.last
            && i_info_r.rd);
         if (done_w && i_info_r.tag == TG_EX && i_info_r.rd) begin
            ex_rdata_r <= asm_w;
         end
      end
   end

   // coprocessor word: operand held between its memory and device cycles
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cp_busy_r <= 1'b0; // R16
         cp_ack_r <= 1'b0;
         cp_addr_r <= '0;
         cp_data_r <= '0;
      end else begin
         cp_ack_r <= done_w && i_info_r.tag == TG_CP && i_info_r.last;
         if (take_cop) begin // R6
            cp_busy_r <= 1'b1;
            cp_addr_r <= coproc_addr_i;
         end else if (done_w && i_info_r.tag == TG_CP && i_info_r.last) begin
            cp_busy_r <= 1'b0;
         end
         if (done_w && i_info_r.tag == TG_CP && i_info_r.rd) begin
            cp_data_r <= asm_w;
         end
      end
   end

   // hold granted only on a quiet bus, kept while requested
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_ack_r <= 1'b0;
      end else begin
         hold_ack_r <= hold_req_i && (hold_ack_r || (!unit_busy // R13
            && !breq_r && !infl_r && !lock_can));
      end
   end

   // prefetches in flight reserve fifo room so a return never drops
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pfo_r <= 2'h0;
         pf_ack_r <= 1'b0;
      end else begin
         pf_ack_r <= take_pf;
         pfo_r <= pfo_r + {1'b0, take_pf}
            - {1'b0, done_w && i_info_r.tag == TG_PF};
      end
   end

   // cycle count of a coprocessor word, watched by the checks below
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cp_cnt_r <= 2'h0;
      end else if (take_cop) begin
         cp_cnt_r <= 2'h0;
      end else if (done_w && i_info_r.tag == TG_CP) begin
         cp_cnt_r <= cp_cnt_r + 2'h1;
      end
   end

   // prefetch words wait here until the prefetcher drains them
   cbs_fifo #(
      .WIDTH(`CBS_WORD_W),
      .DEPTH(`CBS_PF_DEPTH)
   ) u_pf_fifo (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(done_w && i_info_r.tag == TG_PF),
      .in_ready_o(fifo_in_rdy),
      .in_data_i(bus_rdata_i),
      .out_valid_o(pf_valid_o),
      .out_ready_i(pf_ready_i),
      .out_data_o(pf_data_o),
      .count_o(pf_cnt)
   );

   assign exec_ack_o = ex_ack_r;
   assign exec_rdata_o = ex_rdata_r;
   assign pf_ack_o = pf_ack_r;
   assign coproc_ack_o = cp_ack_r;
   assign hold_ack_o = hold_ack_r;
   assign bus_req_o = breq_r;
   assign bus_cmd_o = bcmd_r;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_write_posted;
      exec_req_i && exec_cmd_i.write && !ds_vld_r && !ex_ack_r;
   endsequence
   sequence s_released;
      ex_ack_r && ds_vld_r;
   endsequence

   a_data_over_pf: assert property (take_pf |-> !ex_can) // R1
      else $error("prefetch granted over data");
   a_pf_kept: assert property (infl_r && !bus_done_i // R2
      |=> infl_r && $stable(i_info_r))
      else $error("running cycle replaced");
   a_write_post: assert property (s_write_posted |=> s_released) // R3
      else $error("posted write not taken");
   a_one_slot: assert property (ds_vld_r && ds_r.write |=> !ex_ack_r) // R4
      else $error("second write released");
   a_back_to_back: assert property (bus_accept_i && ex_can // R5
      && !hold_req_i && !hold_ack_r |=> bus_req_o)
      else $error("idle gap before data");
   a_cop_started: assert property ($rose(cp_busy_r) // R6
      |-> $past(coproc_transfer_request_i))
      else $error("coprocessor transfer unrequested");
   a_cop_first: assert property ((take_pf || (take_ds && !ds_r.lock)) // R7
      |-> !cop_can)
      else $error("coprocessor passed over");
   a_cop_two: assert property (cp_ack_r |-> cp_cnt_r >= 2'h2) // R8
      else $error("coprocessor word under two cycles");
   a_same_shake: assert property (bus_req_o && !bus_accept_i // R9
      |=> bus_req_o && $stable(bus_cmd_o))
      else $error("cycle withdrawn before accept");
   a_cop_atomic: assert property (cp_busy_r && go_w // R10
      |-> st_info.tag == TG_CP)
      else $error("cycle inside coprocessor word");
   a_cop_word: assert property (bus_req_o && bus_cmd_o.coproc // R11
      && bus_cmd_o.io |-> bus_cmd_o.be == `CBS_BE_WORD)
      else $error("coprocessor byte cycle");
   a_cop_split: assert property (cp_ack_r |-> cp_cnt_r // R12
      == (cp_addr_r[0] ? `CBS_CP_CNT_SPLIT : `CBS_CP_CNT_WORD))
      else $error("wrong coprocessor cycle count");
   a_hold_quiet: assert property (hold_ack_o // R13
      |-> !bus_req_o && !infl_r)
      else $error("hold on a busy bus");
   a_pf_level: assert property (take_pf // R14
      |-> pf_empty_i >= `CBS_PF_MIN_EMPTY)
      else $error("prefetch with full queue");
   a_pf_quiet: assert property (take_pf |-> !exec_soon_i) // R15
      else $error("prefetch despite data notice");
   a_reset_clear: assert property (disable iff (1'b0) !reset_n_i // R16
      ##1 !reset_n_i |-> !bus_req_o && !ds_vld_r && !cp_busy_r
      && seq_r == SQ_IDLE)
      else $error("state left over in reset");
endmodule

// ==== testbench/cbs_bus_model.sv ====
// cbs_bus_model: local bus cycle generator standing behind the scheduler
// assumes one clock; wait_i sets the clocks between accept and done
module cbs_bus_model
   import cbs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [3:0] wait_i,
   input wire logic req_i,
   input wire cbs_cycle_t cmd_i,
   output logic accept_o,
   output logic done_o,
   output cbs_word_t rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_r;
   logic [3:0] cnt_r;
   cbs_addr_t addr_r;
   // memory and port content made from the address, so reads are known
   function automatic cbs_word_t pat(input cbs_addr_t a);
      return {a[7:0] ^ 8'h3C, ~a[7:0]};
   endfunction
   // one cycle at a time; every kind of cycle gets the same handshake
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         addr_r <= '0;
         accept_o <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         accept_o <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= ~rdata_o; // no stale data outside the done cycle
         if (!busy_r && req_i && !accept_o) begin
            accept_o <= 1'b1;
            busy_r <= 1'b1;
            cnt_r <= wait_i;
            addr_r <= cmd_i.addr;
         end else if (busy_r && cnt_r == 4'h0) begin
            done_o <= 1'b1;
            busy_r <= 1'b0;
            rdata_o <= pat(addr_r);
         end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule

// ==== testbench/test_cpu_bus_request_scheduler.sv ====
// test_cpu_bus_request_scheduler: self-checking bench of the scheduler
// assumes cbs_pkg and cbs_bus_model are compiled before it
`include "cbs_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
`define WAITHI(s) for (int k = 0; k < 400 && s !== 1'b1; k++) \
   @(negedge clk_sys_i);
module test_cpu_bus_request_scheduler
   import cbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, exec_req_i = 1'b0;
   logic exec_soon_i = 1'b0, pf_ready_i = 1'b1, cp_req = 1'b0;
   logic cp_dir = 1'b0, hold_req_i = 1'b0;
   logic exec_ack_o, pf_ack_o, pf_valid_o, coproc_ack_o, hold_ack_o;
   logic bus_req_o, bus_accept_i, bus_done_i;
   logic [2:0] pf_empty_i = 3'h0;
   logic [3:0] bus_wait = 4'h1;
   cbs_xreq_t exec_cmd_i = '0;
   cbs_addr_t pf_addr_i = 24'h000400, cp_addr = 24'h000800;
   cbs_word_t exec_rdata_o, pf_data_o, bus_rdata_i, w;
   cbs_cycle_t bus_cmd_o;
   cbs_cycle_t seen[$];
   int mismatches = 0, num_checks = 0, cyc = 0, ndone = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   cbs_scheduler i_cbs_scheduler (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .exec_req_i(exec_req_i),
      .exec_cmd_i(exec_cmd_i), .exec_soon_i(exec_soon_i),
      .exec_ack_o(exec_ack_o), .exec_rdata_o(exec_rdata_o),
      .pf_empty_i(pf_empty_i), .pf_addr_i(pf_addr_i), .pf_ack_o(pf_ack_o),
      .pf_valid_o(pf_valid_o), .pf_ready_i(pf_ready_i),
      .pf_data_o(pf_data_o), .coproc_transfer_request_i(cp_req),
      .coproc_to_mem_i(cp_dir), .coproc_addr_i(cp_addr),
      .coproc_ack_o(coproc_ack_o), .hold_req_i(hold_req_i),
      .hold_ack_o(hold_ack_o), .bus_req_o(bus_req_o),
      .bus_cmd_o(bus_cmd_o), .bus_accept_i(bus_accept_i),
      .bus_done_i(bus_done_i), .bus_rdata_i(bus_rdata_i));
   cbs_bus_model i_cbs_bus_model (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .wait_i(bus_wait), .req_i(bus_req_o),
      .cmd_i(bus_cmd_o), .accept_o(bus_accept_i), .done_o(bus_done_i),
      .rdata_o(bus_rdata_i));

   // log each taken cycle mid-cycle, where everything has settled
   always @(negedge clk_sys_i) begin
      if (bus_req_o && bus_accept_i)
         seen.push_back(bus_cmd_o);
      if (bus_done_i)
         ndone++;
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic exec_op(input logic wr, input cbs_addr_t a, cbs_word_t d);
      exec_cmd_i = '{addr: a, data: d, write: wr, io: 1'b0, lock: 1'b0};
      exec_req_i = 1'b1;
      `WAITHI(exec_ack_o)
      `CHK(exec_ack_o, 1'b1)
      exec_req_i = 1'b0;
   endtask

   // a write posted behind a running prefetch, then a second one stalls
   task automatic s_post();
      int t;
      bus_wait = 4'h8;
      seen.delete();
      pf_empty_i = 3'h6;
      `WAITHI(pf_ack_o)
      pf_empty_i = 3'h0;
      tick(2);
      t = ndone;
      exec_op(1'b1, 24'h000010, 16'h1234);
      `CHK(ndone, t)
      `CHK(seen.size(), 1)
      tick(1);
      exec_op(1'b1, 24'h000021, 16'hABCD);
      `CHK(ndone >= t + 2, 1'b1)
      tick(40);
      `CHK(seen[1], cbs_cycle_t'({24'h000010, 16'h1234, 5'b10011, 1'b0}))
      `CHK(seen[2].addr, 24'h000021)
      `CHK(seen[2].be, 2'h2)
      `CHK(seen[3].be, 2'h1)
   endtask

   // coprocessor, data and prefetch all ask in the same slot
   task automatic s_prio();
      bus_wait = 4'h1;
      seen.delete();
      cp_dir = 1'b0;
      cp_addr = 24'h000800;
      cp_req = 1'b1;
      exec_cmd_i = '{addr: 24'h30, data: 16'h0, write: 1'b0, io: 1'b0,
                     lock: 1'b0};
      exec_req_i = 1'b1;
      pf_empty_i = 3'h6;
      for (int i = 0; i < 200 && (cp_req || exec_req_i); i++) begin
         @(negedge clk_sys_i);
         if (coproc_ack_o === 1'b1)
            cp_req = 1'b0;
         if (exec_ack_o === 1'b1) begin
            `CHK(exec_rdata_o, i_cbs_bus_model.pat(24'h30))
            exec_req_i = 1'b0;
         end
      end
      `CHK(cp_req | exec_req_i, 1'b0)
      pf_empty_i = 3'h0;
      tick(20);
      `CHK(seen[0].addr, 24'h000800)
      `CHK(seen[1].addr, `CBS_COP_PORT)
      `CHK(seen[1].wdata, i_cbs_bus_model.pat(24'h800))
      `CHK(seen[1].be, 2'h3)
      `CHK(seen[2].addr, 24'h000030)
      `CHK(seen[3].addr, pf_addr_i)
   endtask

   // coprocessor to memory at an odd address: three cycles
   task automatic s_odd();
      seen.delete();
      cp_dir = 1'b1;
      cp_addr = 24'h000901;
      cp_req = 1'b1;
      `WAITHI(coproc_ack_o)
      `CHK(coproc_ack_o, 1'b1)
      cp_req = 1'b0;
      w = i_cbs_bus_model.pat(`CBS_COP_PORT);
      `CHK(seen.size(), 3)
      `CHK({seen[0].io, seen[0].write, seen[0].be}, 4'hB)
      `CHK({seen[1].addr, seen[1].be}, {24'h000901, 2'h2})
      `CHK({seen[2].addr, seen[2].be}, {24'h000902, 2'h1})
      `CHK({seen[1].wdata[15:8], seen[2].wdata[7:0]}, {w[7:0], w[15:8]})
   endtask

   // prefetch gating, then fill the prefetch buffer and drain it
   task automatic s_fifo();
      seen.delete();
      pf_ready_i = 1'b0;
      pf_empty_i = 3'h6;
      exec_soon_i = 1'b1;
      tick(20);
      `CHK(seen.size(), 0)
      exec_soon_i = 1'b0;
      pf_empty_i = 3'h1;
      tick(20);
      `CHK(seen.size(), 0)
      pf_empty_i = 3'h2;
      tick(150);
      `CHK(seen.size(), 8)
      pf_empty_i = 3'h0;
      pf_ready_i = 1'b1;
      repeat (8) begin
         `CHK(pf_valid_o, 1'b1)
         `CHK(pf_data_o, i_cbs_bus_model.pat(pf_addr_i))
         tick(1);
      end
      `CHK(pf_valid_o, 1'b0)
   endtask

   // hold given on an idle bus, then a reset during a stalled write
   task automatic s_hold_reset();
      hold_req_i = 1'b1;
      tick(3);
      `CHK(hold_ack_o, 1'b1)
      hold_req_i = 1'b0;
      tick(2);
      `CHK(hold_ack_o, 1'b0)
      bus_wait = 4'hC;
      exec_op(1'b1, 24'h000040, 16'h5555);
      tick(1);
      exec_cmd_i.addr = 24'h000050;
      exec_req_i = 1'b1;
      tick(2);
      reset_n_i = 1'b0;
      tick(1);
      `CHK({bus_req_o, exec_ack_o}, 2'b00)
      exec_req_i = 1'b0;
      tick(1);
      reset_n_i = 1'b1;
      seen.delete();
      tick(20);
      `CHK(seen.size(), 0)
   endtask

   initial begin
      tick(6);
      reset_n_i = 1'b1;
      tick(2);
      s_post();
      tick(5);
      s_prio();
      tick(5);
      s_odd();
      tick(5);
      s_fifo();
      tick(5);
      s_hold_reset();
      final_report();
   end
endmodule
